//--- core/ocp_channel.sv
// Output compare / PWM channel with two local 16-bit time bases and a plain register port.
// Assumes synchronous inputs on clk_sys, one time base tick per count enable pulse.
//
// The strobed register port and the register addresses were decided locally.
`default_nettype none
`include "ocp_consts.svh"

module ocp_channel
    import ocp_pkg::*;
#(
    parameter logic [3:0] CHANNEL_NUM = 4'h1    // Channel index 1..8
) (
    input  wire logic        clk_sys,        // System clock, 10 MHz
    input  wire logic        reset,          // Asynchronous reset, active high
    input  wire logic [3:0]  reg_addr,       // Register index
    input  wire logic [15:0] reg_wdata,      // Write data
    input  wire logic        reg_wr,         // Write strobe
    input  wire logic        reg_rd,         // Read strobe
    output logic      [15:0] reg_rdata,      // Read data, cycle after strobe
    input  wire logic        tick_en,        // Time base count enable pulse
    input  wire logic        cpu_idle,       // Processor in idle mode
    input  wire logic        fault_input_a,  // Fault input, active low
    input  wire logic        fault_input_b,  // Fault input, active low
    output logic             compare_output_pin, // Compare output
    output logic             compare_irq_flag,   // Sticky interrupt flag
    output logic             dma_req         // One-cycle DMA request
);

    // Control and value registers
    logic [15:0] ctrl_q, ctrl_d;                  // Control word
    logic [15:0] pri_q, pri_d;                    // primary_compare_value
    logic [15:0] sec_q, sec_d;                    // secondary_compare_value
    logic [15:0] cnt2_q, cnt2_d, cnt3_q, cnt3_d;  // Time base counts
    logic [15:0] per2_q, per2_d, per3_q, per3_d;  // Period values
    logic        run2_q, run2_d, run3_q, run3_d;  // time_base_run bits
    logic        pin_q, pin_d;                    // Output pin register
    logic        irq_q, irq_d;                    // Interrupt flag
    logic        flt_q, flt_d;                    // fault_status_flag
    logic        dma_q, dma_d;                    // DMA pulse
    ocp_state_t  st_q, st_d;                      // Pulse sequencer
    logic [15:0] rdata_q, rdata_d;                // Read data

    // Decoded fields and helpers
    ocp_mode_t   mode;                // compare_mode_sel
    logic        time_base_select;    // Picks third timer when set
    logic        idle_halt_ctl;       // Halt in idle
    logic        halted;              // Channel frozen
    logic [15:0] tb_cnt;              // Selected time_base_count
    logic [15:0] tb_per;              // Selected period_value
    logic        tb_step;             // Selected time base advances this cycle
    logic        fault_sel;           // Fault input for this channel
    logic        mode_wr;             // Control write rewrites mode
    logic        pwm;                 // Either PWM mode
    logic        period_hit;          // Count equals period on a step
    logic        pri_hit;             // Primary match on a step
    logic        sec_hit;             // Secondary match on a step
    logic        event_flag;          // Hardware sets the irq flag

    assign mode             = ocp_mode_t'(ctrl_q[2:0]);
    assign time_base_select = ctrl_q[`OCP_CTRL_TSEL_BIT];
    assign idle_halt_ctl    = ctrl_q[`OCP_CTRL_IDLE_BIT];
    assign halted           = idle_halt_ctl && cpu_idle;
    assign tb_cnt           = time_base_select ? cnt3_q : cnt2_q;
    assign tb_per           = time_base_select ? per3_q : per2_q;
    assign tb_step          = tick_en && !halted && (time_base_select ? run3_q : run2_q);
    // Fault inputs are active low; channel number picks which one applies
    assign fault_sel        = (CHANNEL_NUM <= `OCP_FLT_A_LAST_CH)
                              ? !fault_input_a : !fault_input_b;
    assign mode_wr          = reg_wr && (reg_addr == `OCP_ADDR_CTRL);
    assign pwm              = (mode == OCP_MODE_PWM) || (mode == OCP_MODE_PWMF);
    // Matches are sampled only on the count step, so each fires once
    assign period_hit       = tb_step && (tb_cnt == tb_per);
    assign pri_hit          = tb_step && (tb_cnt == pri_q);
    assign sec_hit          = tb_step && (tb_cnt == sec_q);

    // Time base next values; the channel halt also freezes both counters
    always_comb begin
        cnt2_d = cnt2_q;
        cnt3_d = cnt3_q;
        per2_d = per2_q;
        per3_d = per3_q;
        run2_d = run2_q;
        run3_d = run3_q;
        if (tick_en && !halted && run2_q) begin
            // Wrap at period so N gives N+1 counts
            cnt2_d = (cnt2_q == per2_q) ? `OCP_ZERO16 : cnt2_q + 16'h0001;
        end
        if (tick_en && !halted && run3_q) begin
            cnt3_d = (cnt3_q == per3_q) ? `OCP_ZERO16 : cnt3_q + 16'h0001;
        end
        if (reg_wr) begin
            if (reg_addr == `OCP_ADDR_TB2_COUNT) begin
                cnt2_d = reg_wdata;
            end else if (reg_addr == `OCP_ADDR_TB2_PERIOD) begin
                per2_d = reg_wdata;
            end else if (reg_addr == `OCP_ADDR_TB3_COUNT) begin
                cnt3_d = reg_wdata;
            end else if (reg_addr == `OCP_ADDR_TB3_PERIOD) begin
                per3_d = reg_wdata;
            end else if (reg_addr == `OCP_ADDR_STATUS) begin
                run2_d = reg_wdata[`OCP_STAT_RUN2_BIT];
                run3_d = reg_wdata[`OCP_STAT_RUN3_BIT];
            end
        end
    end

    // Time base registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt2_q <= `OCP_ZERO16;
            cnt3_q <= `OCP_ZERO16;
            per2_q <= 16'hffff;
            per3_q <= 16'hffff;
            run2_q <= 1'b0;
            run3_q <= 1'b0;
        end else begin
            cnt2_q <= cnt2_d;
            cnt3_q <= cnt3_d;
            per2_q <= per2_d;
            per3_q <= per3_d;
            run2_q <= run2_d;
            run3_q <= run3_d;
        end
    end

    // Compare engine: control writes, value loads, output and flags
    always_comb begin
        ctrl_d     = ctrl_q;
        pri_d      = pri_q;
        sec_d      = sec_q;
        pin_d      = pin_q;
        st_d       = st_q;
        flt_d      = flt_q;
        dma_d      = 1'b0;
        event_flag = 1'b0;
        // Software writes; primary is locked in PWM
        if (reg_wr && reg_addr == `OCP_ADDR_PRIMARY && !pwm) begin
            pri_d = reg_wdata;
        end
        if (reg_wr && reg_addr == `OCP_ADDR_SECONDARY) begin
            sec_d = reg_wdata;
        end
        case (mode)
            OCP_MODE_OFF: begin
                pin_d = 1'b0;
            end
            OCP_MODE_HIGH: begin
                if (pri_hit) begin
                    pin_d      = 1'b1;
                    event_flag = 1'b1;
                end
            end
            OCP_MODE_LOW: begin
                if (pri_hit) begin
                    pin_d      = 1'b0;
                    event_flag = 1'b1;
                end
            end
            OCP_MODE_TOGGLE: begin
                if (pri_hit) begin
                    pin_d      = !pin_q;
                    event_flag = 1'b1;
                end
            end
            OCP_MODE_SINGLE, OCP_MODE_CONT: begin
                case (st_q)
                    OCP_ST_WAIT_RISE: begin
                        if (pri_hit) begin
                            pin_d = 1'b1;
                            st_d  = OCP_ST_WAIT_FALL;
                        end
                    end
                    OCP_ST_WAIT_FALL: begin
                        if (sec_hit) begin
                            pin_d      = 1'b0;
                            event_flag = 1'b1;
                            // Single pulse parks; continuous rearms
                            st_d = (mode == OCP_MODE_SINGLE)
                                   ? OCP_ST_DONE : OCP_ST_WAIT_RISE;
                        end
                    end
                    default: begin
                        pin_d = 1'b0;
                    end
                endcase
            end
            default: begin
                // PWM: duty reload at period end, level from count vs duty
                if (flt_q && mode == OCP_MODE_PWMF) begin
                    pin_d = 1'b0;
                end else if (fault_sel && mode == OCP_MODE_PWMF) begin
                    pin_d      = 1'b0;
                    flt_d      = 1'b1;
                    event_flag = 1'b1;
                end else if (period_hit) begin
                    pri_d = sec_q;
                    // Next count is zero: high unless the new duty is zero
                    pin_d = (sec_q != `OCP_ZERO16);
                    event_flag = 1'b1;
                end else if (tb_step) begin
                    // Low from count duty upward when duty within period
                    if (pri_q == `OCP_ZERO16) begin
                        pin_d = 1'b0;
                    end else if (pri_q > tb_per) begin
                        pin_d = 1'b1;
                    end else if (tb_cnt + 16'h0001 >= pri_q) begin
                        pin_d = 1'b0;
                    end else begin
                        pin_d = 1'b1;
                    end
                end
            end
        endcase
        // A mode write restarts the sequence from the documented initial level
        if (mode_wr) begin
            ctrl_d = reg_wdata & `OCP_CTRL_WMASK;
            st_d   = OCP_ST_WAIT_RISE;
            flt_d  = 1'b0;
            case (ocp_mode_t'(reg_wdata[2:0]))
                OCP_MODE_LOW: pin_d = 1'b1;
                OCP_MODE_PWM, OCP_MODE_PWMF: pin_d = (pri_q != `OCP_ZERO16);
                default: pin_d = 1'b0;
            endcase
        end
        if (event_flag && CHANNEL_NUM != 4'h0 && CHANNEL_NUM <= `OCP_DMA_LAST_CH) begin
            dma_d = 1'b1;
        end
    end

    // Interrupt flag: set wins over a software clear in the same cycle
    always_comb begin
        irq_d = irq_q;
        if (reg_wr && reg_addr == `OCP_ADDR_STATUS && reg_wdata[`OCP_STAT_IRQ_BIT]) begin
            irq_d = 1'b0;
        end
        if (event_flag) begin
            irq_d = 1'b1;
        end
    end

    // Read mux: decoded as an if chain, unmapped reads zero
    always_comb begin
        rdata_d = `OCP_ZERO16;
        if (reg_rd) begin
            if (reg_addr == `OCP_ADDR_CTRL) begin
                rdata_d = (ctrl_q & `OCP_CTRL_WMASK) | {11'h000, flt_q, 4'h0};
            end else if (reg_addr == `OCP_ADDR_PRIMARY) begin
                rdata_d = pri_q;
            end else if (reg_addr == `OCP_ADDR_SECONDARY) begin
                rdata_d = sec_q;
            end else if (reg_addr == `OCP_ADDR_TB2_COUNT) begin
                rdata_d = cnt2_q;
            end else if (reg_addr == `OCP_ADDR_TB2_PERIOD) begin
                rdata_d = per2_q;
            end else if (reg_addr == `OCP_ADDR_TB3_COUNT) begin
                rdata_d = cnt3_q;
            end else if (reg_addr == `OCP_ADDR_TB3_PERIOD) begin
                rdata_d = per3_q;
            end else if (reg_addr == `OCP_ADDR_STATUS) begin
                rdata_d = {13'h0000, run3_q, run2_q, irq_q};
            end
        end
    end

    // Channel state registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ctrl_q  <= `OCP_CTRL_RESET;
            pri_q   <= `OCP_ZERO16;
            sec_q   <= `OCP_ZERO16;
            pin_q   <= 1'b0;
            st_q    <= OCP_ST_WAIT_RISE;
            flt_q   <= 1'b0;
            irq_q   <= 1'b0;
            dma_q   <= 1'b0;
            rdata_q <= `OCP_ZERO16;
        end else begin
            ctrl_q  <= ctrl_d;
            pri_q   <= pri_d;
            sec_q   <= sec_d;
            pin_q   <= pin_d;
            st_q    <= st_d;
            flt_q   <= flt_d;
            irq_q   <= irq_d;
            dma_q   <= dma_d;
            rdata_q <= rdata_d;
        end
    end

    assign compare_output_pin = pin_q;
    assign compare_irq_flag   = irq_q;
    assign dma_req            = dma_q;
    assign reg_rdata          = rdata_q;

endmodule
`default_nettype wire

//--- core/ocp_consts.svh
// Constants for the output compare / PWM channel: register offsets, field positions, codes.
// Assumes inclusion by bare name from the design file, the checker and the testbench.
`ifndef OCP_CONSTS_SVH
`define OCP_CONSTS_SVH

// Register indices on the plain register port (4-bit address)
`define OCP_ADDR_CTRL        4'h0
`define OCP_ADDR_PRIMARY     4'h1
`define OCP_ADDR_SECONDARY   4'h2
`define OCP_ADDR_TB2_COUNT   4'h3
`define OCP_ADDR_TB2_PERIOD  4'h4
`define OCP_ADDR_TB3_COUNT   4'h5
`define OCP_ADDR_TB3_PERIOD  4'h6
`define OCP_ADDR_STATUS      4'h7

// Control register fields
`define OCP_CTRL_IDLE_BIT    13
`define OCP_CTRL_FAULT_BIT   4
`define OCP_CTRL_TSEL_BIT    3
`define OCP_CTRL_WMASK       16'h200f
`define OCP_CTRL_RESET       16'h0000

// Status register fields: bit0 irq flag (write 1 to clear), bit1 tb2 run, bit2 tb3 run
`define OCP_STAT_IRQ_BIT     0
`define OCP_STAT_RUN2_BIT    1
`define OCP_STAT_RUN3_BIT    2

// Channel number strapping range
`define OCP_FLT_A_LAST_CH    4'h4
`define OCP_DMA_LAST_CH      4'h2

`define OCP_ZERO16           16'h0000
`endif

//--- core/ocp_pkg.sv
// Types for the output compare / PWM channel.
// Assumes ocp_consts.svh is on the include path.
`default_nettype none
package ocp_pkg;
    // Compare mode codes
    typedef enum logic [2:0] {
        OCP_MODE_OFF    = 3'b000,
        OCP_MODE_HIGH   = 3'b001,
        OCP_MODE_LOW    = 3'b010,
        OCP_MODE_TOGGLE = 3'b011,
        OCP_MODE_SINGLE = 3'b100,
        OCP_MODE_CONT   = 3'b101,
        OCP_MODE_PWM    = 3'b110,
        OCP_MODE_PWMF   = 3'b111
    } ocp_mode_t;

    // Pulse sequencer state
    typedef enum logic [1:0] {
        OCP_ST_WAIT_RISE = 2'b00,
        OCP_ST_WAIT_FALL = 2'b01,
        OCP_ST_DONE      = 2'b10
    } ocp_state_t;
endpackage
`default_nettype wire

//--- tb/ocp_channel_chk.sv
// Port-level assertions for the compare channel.
// Assumes one clk_sys domain; bound onto every ocp_channel instance.
`default_nettype none
`include "ocp_consts.svh"
module ocp_channel_chk
    import ocp_pkg::*;
#(
    parameter logic [3:0] CHANNEL_NUM = 4'h1  // Channel index
) (
    input wire logic        clk_sys,             // System clock
    input wire logic        reset,               // Asynchronous reset
    input wire logic [3:0]  reg_addr,            // Register index
    input wire logic [15:0] reg_wdata,           // Write data
    input wire logic        reg_wr,              // Write strobe
    input wire logic        reg_rd,              // Read strobe
    input wire logic [15:0] reg_rdata,           // Read data
    input wire logic        tick_en,             // Count enable
    input wire logic        cpu_idle,            // Processor idle
    input wire logic        fault_input_a,       // Fault A, active low
    input wire logic        fault_input_b,       // Fault B, active low
    input wire logic        compare_output_pin,  // Compare output
    input wire logic        compare_irq_flag,    // Interrupt flag
    input wire logic        dma_req              // DMA request
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic       ctrl_wr;  // Control register write
    logic       flt_act;  // Assigned fault input active
    logic [2:0] mode_q;   // Mirror of the mode field
    logic       halt_q;   // Mirror of the idle halt bit
    logic       flt_q;    // Fault latched in mode 111

    assign ctrl_wr = reg_wr && (reg_addr == `OCP_ADDR_CTRL);
    assign flt_act = (CHANNEL_NUM <= `OCP_FLT_A_LAST_CH) ? !fault_input_a : !fault_input_b;

    // Mirror control fields; any control write drops the fault latch
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode_q <= 3'h0;
            halt_q <= 1'b0;
            flt_q  <= 1'b0;
        end else if (ctrl_wr) begin
            mode_q <= reg_wdata[2:0];
            halt_q <= reg_wdata[13];
            flt_q  <= 1'b0;
        end else if (mode_q == 3'h7 && flt_act) begin
            flt_q <= 1'b1;
        end
    end

    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    unmapped_rd_a: assert property (reg_rd && reg_addr > 4'h7 |=> reg_rdata == 16'h0000)
        else $error("unmapped read returned data");
    ctrl_unimpl_a: assert property (reg_rd && reg_addr == `OCP_ADDR_CTRL |=> (reg_rdata & 16'hdfe0) == 16'h0000)
        else $error("unimplemented control bits read high");
    off_low_a: assert property (mode_q == 3'h0 && !ctrl_wr |=> !compare_output_pin)
        else $error("output high while disabled");
    init_low_a: assert property (ctrl_wr && reg_wdata[2:0] inside {3'h4, 3'h5} |=> !compare_output_pin)
        else $error("pulse mode did not start low");
    irq_sticky_a: assert property (compare_irq_flag && !(reg_wr && reg_addr == `OCP_ADDR_STATUS && reg_wdata[0]) |=> compare_irq_flag)
        else $error("flag dropped without clear");
    dma_gate_a: assert property (dma_req |-> compare_irq_flag && CHANNEL_NUM <= `OCP_DMA_LAST_CH)
        else $error("dma request without flag or channel");
    dma_pulse_a: assert property (dma_req |=> !dma_req)
        else $error("dma request longer than one clock");
    flag_dma_a: assert property ($rose(compare_irq_flag) |-> dma_req == (CHANNEL_NUM <= `OCP_DMA_LAST_CH))
        else $error("flag set without matching dma request");
    fault_hold_a: assert property (flt_q && $past(flt_q) && !ctrl_wr |-> !compare_output_pin)
        else $error("output not held low after fault");
    idle_freeze_a: assert property ((cpu_idle && halt_q && !ctrl_wr)[*3] |-> $stable(compare_output_pin) && !dma_req)
        else $error("channel ran while halted in idle");
endmodule

bind ocp_channel ocp_channel_chk #(.CHANNEL_NUM(CHANNEL_NUM)) u_chk (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_en(tick_en),
    .cpu_idle(cpu_idle), .fault_input_a(fault_input_a), .fault_input_b(fault_input_b),
    .compare_output_pin(compare_output_pin), .compare_irq_flag(compare_irq_flag),
    .dma_req(dma_req));
`default_nettype wire

//--- tb/ocp_load_model.sv
// Load on the compare output pin: measures pulse widths and periods.
// Assumes the pin is a registered level sampled on clk_sys.
`default_nettype none
module ocp_load_model (
    input  wire logic        clk_sys,  // System clock
    input  wire logic        reset,    // Asynchronous reset, active high
    input  wire logic        pin,      // Compare output pin
    output logic      [15:0] rises,    // Rising edges seen
    output logic      [15:0] hi_len,   // Last high width, clocks
    output logic      [15:0] per_len   // Last rise-to-rise time, clocks
);
    logic        pin_q;    // Pin one clock ago
    logic [15:0] hi_cnt;   // Running high width
    logic [15:0] per_cnt;  // Running rise-to-rise time

    // Pure receiver: it never drives the pin, so it cannot mask a fault
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_q   <= 1'b0;
            rises   <= 16'h0000;
            hi_len  <= 16'h0000;
            per_len <= 16'h0000;
            hi_cnt  <= 16'h0000;
            per_cnt <= 16'h0000;
        end else begin
            pin_q   <= pin;
            per_cnt <= per_cnt + 16'h0001;
            hi_cnt  <= hi_cnt + {15'h0000, pin};
            if (pin && !pin_q) begin // Rising edge restarts both counts
                rises   <= rises + 16'h0001;
                per_len <= per_cnt;
                per_cnt <= 16'h0001;
                hi_cnt  <= 16'h0001;
            end
            if (!pin && pin_q) begin // Falling edge closes the pulse
                hi_len <= hi_cnt;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/test_output_compare_pwm_channel.sv
// Register-driven testbench for the compare channel, channel 1.
// Assumes the bound checker and the pin load model beside the design.
`default_nettype none
`include "ocp_consts.svh"
module test_output_compare_pwm_channel;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;        // 10 MHz clock
    logic        reset = 1'b1;          // Held for 4 clocks
    logic [3:0]  reg_addr = 4'h0;       // Register index
    logic [15:0] reg_wdata = 16'h0000;  // Write data
    logic        reg_wr = 1'b0;         // Write strobe
    logic        reg_rd = 1'b0;         // Read strobe
    logic        tick_en = 1'b1;        // One count per clock keeps timing exact
    logic        cpu_idle = 1'b0;       // Idle request
    logic        flt_a_n = 1'b1;        // Fault A, inactive
    logic        flt_b_n = 1'b1;        // Fault B, inactive
    logic [15:0] reg_rdata;             // Read data
    logic        pin;                   // Compare output
    logic        irq;                   // Interrupt flag
    logic        dma;                   // DMA request
    logic [15:0] rises, hi_len, per_len, r; // Load measurements, snapshot
    int          fails = 0;             // Mismatches
    int          total_checks = 0;      // Comparisons

    ocp_channel #(.CHANNEL_NUM(4'h1)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_en(tick_en),
        .cpu_idle(cpu_idle), .fault_input_a(flt_a_n), .fault_input_b(flt_b_n),
        .compare_output_pin(pin), .compare_irq_flag(irq), .dma_req(dma));
    ocp_load_model u_load (.clk_sys(clk_sys), .reset(reset), .pin(pin),
        .rises(rises), .hi_len(hi_len), .per_len(per_len));

    always #50 clk_sys = ~clk_sys;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask
    // One-clock write strobe; the next access starts an edge later
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the clock after the strobe
    task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic complete_run;
        if (fails == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        cyc(4);
        reset <= 1'b0;
        rchk(`OCP_ADDR_CTRL, 16'h0000);
        rchk(`OCP_ADDR_TB2_PERIOD, 16'hffff);
        rchk(4'h9, 16'h0000);
        // Continuous pulses, rise at 3, fall at 6, period 9
        wr(`OCP_ADDR_SECONDARY, 16'h0006);
        wr(`OCP_ADDR_PRIMARY, 16'h0003);
        wr(`OCP_ADDR_TB2_PERIOD, 16'h0009);
        wr(`OCP_ADDR_CTRL, 16'h0005);
        wr(`OCP_ADDR_STATUS, 16'h0002);
        cyc(25);
        chk(hi_len, 16'h0003);
        chk(per_len, 16'h000a);
        chk({15'h0000, irq}, 16'h0001);
        rchk(`OCP_ADDR_STATUS, 16'h0003);
        wr(`OCP_ADDR_STATUS, 16'h0001);                  // Stop timers so no event races the clear
        rchk(`OCP_ADDR_STATUS, 16'h0000);
        wr(`OCP_ADDR_STATUS, 16'h0002);
        // Single pulse, then silence
        wr(`OCP_ADDR_CTRL, 16'h0004);
        r = rises;
        cyc(40);
        chk(rises - r, 16'h0001);
        chk({15'h0000, pin}, 16'h0000);
        // Match modes: force high, force low, toggle
        wr(`OCP_ADDR_CTRL, 16'h0001);
        cyc(25);
        chk({15'h0000, pin}, 16'h0001);
        wr(`OCP_ADDR_CTRL, 16'h0002);
        cyc(25);
        chk({15'h0000, pin}, 16'h0000);
        wr(`OCP_ADDR_CTRL, 16'h0003);
        r = rises;
        cyc(40);
        chk(rises - r, 16'h0002);
        wr(`OCP_ADDR_CTRL, 16'h0000);
        cyc(25);
        chk({15'h0000, pin}, 16'h0000);
        // PWM: duty 4 of 10, primary locked
        wr(`OCP_ADDR_PRIMARY, 16'h0004);
        wr(`OCP_ADDR_SECONDARY, 16'h0004);
        wr(`OCP_ADDR_CTRL, 16'h0006);
        wr(`OCP_ADDR_PRIMARY, 16'h0002);
        rchk(`OCP_ADDR_PRIMARY, 16'h0004);
        cyc(25);
        chk(hi_len, 16'h0004);
        chk(per_len, 16'h000a);
        // Duty load waits for the period match
        wr(`OCP_ADDR_STATUS, 16'h0000);
        wr(`OCP_ADDR_SECONDARY, 16'h0009);
        rchk(`OCP_ADDR_PRIMARY, 16'h0004);
        wr(`OCP_ADDR_STATUS, 16'h0002);
        cyc(25);
        chk(hi_len, 16'h0009);
        rchk(`OCP_ADDR_PRIMARY, 16'h0009);
        // Duty above period, then zero duty
        wr(`OCP_ADDR_SECONDARY, 16'h000a);
        cyc(15);
        r = rises;
        cyc(25);
        chk(rises - r, 16'h0000);
        chk({15'h0000, pin}, 16'h0001);
        wr(`OCP_ADDR_SECONDARY, 16'h0000);
        cyc(15);
        r = rises;
        cyc(25);
        chk(rises - r, 16'h0000);
        chk({15'h0000, pin}, 16'h0000);
        // Fault mode: B is ignored by channel 1, A latches
        wr(`OCP_ADDR_SECONDARY, 16'h0005);
        wr(`OCP_ADDR_CTRL, 16'h0007);
        flt_b_n <= 1'b0;
        cyc(15);
        r = rises;
        cyc(30);
        chk(rises - r, 16'h0003);
        flt_a_n <= 1'b0;
        cyc(3);
        flt_a_n <= 1'b1;
        cyc(25);
        chk({15'h0000, pin}, 16'h0000);
        rchk(`OCP_ADDR_CTRL, 16'h0017);
        wr(`OCP_ADDR_CTRL, 16'h0006);
        flt_a_n <= 1'b0;
        rchk(`OCP_ADDR_CTRL, 16'h0006);
        r = rises;
        cyc(30);
        chk(rises - r, 16'h0003);
        flt_a_n <= 1'b1;
        flt_b_n <= 1'b1;
        // Third timer as time base
        wr(`OCP_ADDR_STATUS, 16'h0001);
        wr(`OCP_ADDR_TB3_PERIOD, 16'h0009);
        wr(`OCP_ADDR_CTRL, 16'h000d);
        wr(`OCP_ADDR_SECONDARY, 16'h0006);
        wr(`OCP_ADDR_PRIMARY, 16'h0003);
        wr(`OCP_ADDR_STATUS, 16'h0004);
        cyc(25);
        chk(hi_len, 16'h0003);
        // Idle with halt set, then with halt clear
        wr(`OCP_ADDR_CTRL, 16'h200d);
        cpu_idle <= 1'b1;
        cyc(3);
        r = rises;
        cyc(30);
        chk(rises - r, 16'h0000);
        wr(`OCP_ADDR_CTRL, 16'h000d);
        cyc(3);
        r = rises;
        cyc(30);
        chk(rises - r, 16'h0003);
        cpu_idle <= 1'b0;
        complete_run();
    end
endmodule
`default_nettype wire
